// ==== rtl/lcb_core.sv ====
// Functional notes
// - Pixel bit one dark, zero clear
// - Three frame clock sources, two-bit select
// - System clock divided by fixed 256
// - Four-bit prescaler, ratios 1:1 to 1:16
// - Prescaler count hidden from software
// - Oscillator sources keep running in sleep
// - Static, half and third bias supported
// - Half bias shorts middle ladder resistor
// - Inactive display forces ladder off
// - Ladder low, medium, high or off
// - Mode A after transition, then B
// - Three-bit interval A length, zero none
// - Interval timed by five-bit base prescaler, crystal and LFOSC sources only
// - Power code 00 off, 01 low
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "lcb_defs.svh"
module lcb_core (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   input  wire logic        sleep,
   input  wire logic        xtal_clk,
   input  wire logic        lfosc_clk,
   output logic      [31:0] pixel_bit,
   output logic      [1:0]  ladder_power,
   output logic             ladder_connected,
   output logic             ladder_mid_short,
   output logic      [1:0]  bias_mode,
   output logic             display_active_flag,
   output logic             frame_tick,
   output logic      [1:0]  frame_phase
);
   localparam int NPIX = `LCB_PIXEL_REGS;

   typedef struct packed {
      logic [7:0]            ctrl;
      logic [3:0]            prescale;
      logic [7:0]            ladder;
      logic [NPIX-1:0][7:0]  pixels;
      logic [7:0]            rdata;
      logic                  active;
      logic [1:0]            phase;
      logic [2:0]            a_count;
      logic                  in_a;
   } lcb_st_t;
   lcb_st_t st_reg;
   lcb_st_t st_next;

   logic            xtal_tick;
   logic            lf_tick;
   logic            sys_tick;
   logic            src_tick;
   logic            fr_tick;
   logic            base_tick;
   logic            xl_tick;
   logic            run_ok;
   lcb_pkg::lcb_src_t src;
   lcb_pkg::lcb_pwr_t pwr_a;
   lcb_pkg::lcb_pwr_t pwr_b;
   lcb_pkg::lcb_pwr_t pwr_sel;

   lcb_sync u_sync_xtal (
      .clock    (clock),
      .rst      (rst),
      .ce       (ce),
      .async_in (xtal_clk),
      .rise     (xtal_tick)
   );

   lcb_sync u_sync_lf (
      .clock    (clock),
      .rst      (rst),
      .ce       (ce),
      .async_in (lfosc_clk),
      .rise     (lf_tick)
   );

   lcb_divider #(.WIDTH(8)) u_sysdiv (
      .clock    (clock),
      .rst      (rst),
      .ce       (ce),
      .tick_in  (1'b1),
      .limit    (8'((`LCB_SYS_DIV) - 1)),
      .tick_out (sys_tick)
   );

   assign src = lcb_pkg::lcb_src_t'(st_reg.ctrl[`LCB_CTRL_SRC_LSB +: 2]);

   // Only oscillator sources run in sleep
   assign run_ok = !sleep || (src == lcb_pkg::LCB_SRC_XTAL) || (src == lcb_pkg::LCB_SRC_LFOSC);

   always_comb begin
      case (src)
         lcb_pkg::LCB_SRC_SYSDIV: src_tick = sys_tick;
         lcb_pkg::LCB_SRC_XTAL:   src_tick = xtal_tick;
         lcb_pkg::LCB_SRC_LFOSC:  src_tick = lf_tick;
         default:                 src_tick = 1'b0;
      endcase
   end

   lcb_divider #(.WIDTH(4)) u_presc (
      .clock    (clock),
      .rst      (rst),
      .ce       (ce),
      .tick_in  (src_tick && run_ok && st_reg.active),
      .limit    (st_reg.prescale),
      .tick_out (fr_tick)
   );

   // Base-rate divider sets interval A steps
   lcb_divider #(.WIDTH(5)) u_base (
      .clock    (clock),
      .rst      (rst),
      .ce       (ce),
      .tick_in  (xl_tick),
      .limit    (5'((`LCB_BASE_DIV) - 1)),
      .tick_out (base_tick)
   );
   assign xl_tick = (src == lcb_pkg::LCB_SRC_SYSDIV) ? 1'b0 : (src_tick && run_ok && st_reg.active);

   assign pwr_a = lcb_pkg::lcb_pwr_t'(st_reg.ladder[`LCB_LAD_APWR_LSB +: 2]);
   assign pwr_b = lcb_pkg::lcb_pwr_t'(st_reg.ladder[`LCB_LAD_BPWR_LSB +: 2]);

   always_comb begin
      st_next       = st_reg;
      st_next.rdata = st_reg.rdata;
      if (wr) begin
         case (addr)
            `LCB_OFF_CTRL:     st_next.ctrl = wdata;
            `LCB_OFF_PRESCALE: st_next.prescale = wdata[3:0];
            `LCB_OFF_LADDER:   st_next.ladder = {wdata[7:4], 1'b0, wdata[2:0]};
            default: begin
               for (int i = 0; i < NPIX; i++) begin
                  if (addr == 8'(`LCB_OFF_PIXEL0 + i)) begin
                     st_next.pixels[i] = wdata;
                  end
               end
            end
         endcase
      end
      if (rd) begin
         case (addr)
            `LCB_OFF_CTRL:     st_next.rdata = st_reg.ctrl;
            `LCB_OFF_PRESCALE: st_next.rdata = {4'h0, st_reg.prescale};
            `LCB_OFF_LADDER:   st_next.rdata = st_reg.ladder;
            `LCB_OFF_STATUS:   st_next.rdata = {st_reg.active, st_reg.in_a, 4'h0, st_reg.phase};
            default: begin
               st_next.rdata = 8'h00;
               for (int i = 0; i < NPIX; i++) begin
                  if (addr == 8'(`LCB_OFF_PIXEL0 + i)) begin
                     st_next.rdata = st_reg.pixels[i];
                  end
               end
            end
         endcase
      end
      st_next.active = st_reg.ctrl[`LCB_CTRL_ENABLE];
      // Frame phase steps on prescaler ticks
      if (fr_tick) begin
         st_next.phase   = st_reg.phase + 2'h1;
         st_next.a_count = st_reg.ladder[`LCB_LAD_ALEN_LSB +: 3];
         st_next.in_a    = (st_reg.ladder[`LCB_LAD_ALEN_LSB +: 3] != 3'h0);
      end else if (base_tick && st_reg.in_a) begin
         st_next.a_count = st_reg.a_count - 3'h1;
         st_next.in_a    = (st_reg.a_count > 3'h1);
      end
      if (!st_reg.active) begin
         st_next.in_a  = 1'b0;
         st_next.phase = 2'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg          <= '0;
         st_reg.ctrl     <= `LCB_CTRL_RESET;
         st_reg.ladder   <= `LCB_LAD_RESET;
         st_reg.prescale <= `LCB_PRESCALE_RESET;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // Select ladder mode for current interval
   assign pwr_sel = st_reg.in_a ? pwr_a : pwr_b;

   always_comb begin
      if (!st_reg.active) begin
         ladder_power = lcb_pkg::LCB_PWR_OFF;
      end else begin
         ladder_power = pwr_sel;
      end
   end
   assign ladder_connected = (ladder_power != lcb_pkg::LCB_PWR_OFF);

   always_comb begin
      if (st_reg.ctrl[`LCB_CTRL_STATIC]) begin
         bias_mode = lcb_pkg::LCB_BIAS_STATIC;
      end else if (st_reg.ctrl[`LCB_CTRL_HALF_BIAS]) begin
         bias_mode = lcb_pkg::LCB_BIAS_HALF;
      end else begin
         bias_mode = lcb_pkg::LCB_BIAS_THIRD;
      end
   end
   assign ladder_mid_short = ladder_connected && (bias_mode == lcb_pkg::LCB_BIAS_HALF);

   // Pixel bits drive dark when one
   assign pixel_bit           = st_reg.pixels;
   assign rdata               = st_reg.rdata;
   assign display_active_flag = st_reg.active;
   assign frame_tick          = fr_tick;
   assign frame_phase         = st_reg.phase;

   AST_LADDER_OFF: assert property (@(posedge clock) disable iff (rst)
      !display_active_flag |-> (ladder_power == lcb_pkg::LCB_PWR_OFF && !ladder_connected))
      else $error("ladder on while inactive");
   AST_HALF_SHORT: assert property (@(posedge clock) disable iff (rst)
      (ladder_connected && bias_mode == lcb_pkg::LCB_BIAS_HALF) |-> ladder_mid_short)
      else $error("middle resistor not shorted");
   AST_PIXEL_WRITE: assert property (@(posedge clock) disable iff (rst)
      (ce && wr && addr == `LCB_OFF_PIXEL0) |=> (pixel_bit[7:0] == $past(wdata)))
      else $error("pixel write lost");
   // Zero length means no interval A
   AST_NO_A: assert property (@(posedge clock) disable iff (rst)
      (ce && fr_tick && st_reg.ladder[2:0] == 3'h0) |=> !st_reg.in_a)
      else $error("interval A with zero length");
   AST_A_START: assert property (@(posedge clock) disable iff (rst)
      (ce && fr_tick && st_reg.active && st_reg.ladder[2:0] != 3'h0) |=> st_reg.in_a)
      else $error("interval A not started");
   AST_PHASE_TICK: assert property (@(posedge clock) disable iff (rst)
      (ce && !fr_tick && st_reg.active && $past(st_reg.active)) |=> $stable(st_reg.phase))
      else $error("phase moved without tick");
   // No frame ticks from sysclk in sleep
   AST_SLEEP_STOP: assert property (@(posedge clock) disable iff (rst)
      (sleep && src == lcb_pkg::LCB_SRC_SYSDIV) |-> !fr_tick)
      else $error("sysclk frame tick in sleep");
   // Code 00 in interval B disconnects
   AST_B_OFF: assert property (@(posedge clock) disable iff (rst)
      (!st_reg.in_a && pwr_b == lcb_pkg::LCB_PWR_OFF) |-> !ladder_connected)
      else $error("ladder connected with code 00");
   AST_PRESC_ONE: assert property (@(posedge clock) disable iff (rst)
      (ce && st_reg.prescale == 4'h0 && src_tick && run_ok && st_reg.active) |-> fr_tick)
      else $error("1:1 prescale dropped tick");

   // Control write steps
   sequence s_en_write;
      ce && wr && addr == `LCB_OFF_CTRL && wdata[`LCB_CTRL_ENABLE];
   endsequence

   sequence s_dis_write;
      ce && wr && addr == `LCB_OFF_CTRL && !wdata[`LCB_CTRL_ENABLE];
   endsequence

   sequence s_settle;
      ce [*2];
   endsequence

   AST_ENABLE_SEQ: assert property (@(posedge clock) disable iff (rst)
      s_en_write ##1 s_settle |-> display_active_flag)
      else $error("display not active after enable");

   AST_DISABLE_SEQ: assert property (@(posedge clock) disable iff (rst)
      s_dis_write ##1 s_settle |-> (!display_active_flag && ladder_power == lcb_pkg::LCB_PWR_OFF))
      else $error("ladder on after disable");

   AST_ACTIVE_LAG: assert property (@(posedge clock) disable iff (rst)
      ce |=> (display_active_flag == $past(st_reg.ctrl[`LCB_CTRL_ENABLE])))
      else $error("active flag lag wrong");

   AST_RD_PIXEL: assert property (@(posedge clock) disable iff (rst)
      (ce && rd && addr == `LCB_OFF_PIXEL0) |=> (rdata == $past(pixel_bit[7:0])))
      else $error("pixel read wrong");

   AST_PRESC_HIDDEN: assert property (@(posedge clock) disable iff (rst)
      (ce && rd && addr == `LCB_OFF_PRESCALE) |=> (rdata[7:4] == 4'h0))
      else $error("prescaler count visible");

   AST_RD_UNMAPPED: assert property (@(posedge clock) disable iff (rst)
      (ce && rd && addr == 8'h20) |=> (rdata == 8'h00))
      else $error("unmapped read not zero");

   AST_SYS_LIMIT: assert property (@(posedge clock) disable iff (rst)
      sys_tick |-> (u_sysdiv.st_reg.count == 8'hff))
      else $error("sysclk tick off ratio");

   AST_A_ENDS: assert property (@(posedge clock) disable iff (rst)
      (ce && !fr_tick && base_tick && st_reg.in_a && st_reg.a_count == 3'h1) |=> !st_reg.in_a)
      else $error("interval A did not end");

   AST_A_POWER: assert property (@(posedge clock) disable iff (rst)
      (st_reg.active && st_reg.in_a) |-> (ladder_power == pwr_a))
      else $error("interval A power wrong");

   AST_B_POWER: assert property (@(posedge clock) disable iff (rst)
      (st_reg.active && !st_reg.in_a) |-> (ladder_power == pwr_b))
      else $error("interval B power wrong");

   AST_XTAL_SLEEP: assert property (@(posedge clock) disable iff (rst)
      (ce && sleep && src == lcb_pkg::LCB_SRC_XTAL && xtal_tick && st_reg.active && st_reg.prescale == 4'h0)
      |-> fr_tick)
      else $error("crystal tick lost in sleep");

   AST_BIAS_STATIC: assert property (@(posedge clock) disable iff (rst)
      st_reg.ctrl[`LCB_CTRL_STATIC] |-> (bias_mode == lcb_pkg::LCB_BIAS_STATIC))
      else $error("static bias not selected");

   AST_SRC_NONE: assert property (@(posedge clock) disable iff (rst)
      (src == lcb_pkg::LCB_SRC_RSVD) |-> !fr_tick)
      else $error("frame tick with no source");
endmodule

// ==== rtl/lcb_defs.svh ====
`ifndef LCB_DEFS_SVH
`define LCB_DEFS_SVH
// Register offsets
`define LCB_OFF_CTRL        8'h00
`define LCB_OFF_PRESCALE    8'h01
`define LCB_OFF_LADDER      8'h02
`define LCB_OFF_STATUS      8'h03
`define LCB_OFF_PIXEL0      8'h10
`define LCB_PIXEL_REGS      4
// Control register fields
`define LCB_CTRL_SRC_LSB    0
`define LCB_CTRL_HALF_BIAS  2
`define LCB_CTRL_STATIC     3
`define LCB_CTRL_ENABLE     7
`define LCB_CTRL_RESET      8'h00
// Ladder register fields
`define LCB_LAD_ALEN_LSB    0
`define LCB_LAD_BPWR_LSB    4
`define LCB_LAD_APWR_LSB    6
`define LCB_LAD_RESET       8'h00
`define LCB_PRESCALE_RESET  4'h0
// Fixed divider ratios
`define LCB_SYS_DIV         256
`define LCB_BASE_DIV        32
`endif

// ==== rtl/lcb_pkg.sv ====
package lcb_pkg;
   typedef enum logic [1:0] {
      LCB_SRC_SYSDIV,
      LCB_SRC_XTAL,
      LCB_SRC_LFOSC,
      LCB_SRC_RSVD
   } lcb_src_t;
   typedef enum logic [1:0] {
      LCB_PWR_OFF,
      LCB_PWR_LOW,
      LCB_PWR_MED,
      LCB_PWR_HIGH
   } lcb_pwr_t;
   typedef enum logic [1:0] {
      LCB_BIAS_STATIC,
      LCB_BIAS_HALF,
      LCB_BIAS_THIRD
   } lcb_bias_t;
endpackage

// ==== rtl/lcb_sync.sv ====
`timescale 1ns/1ps
module lcb_sync (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic async_in,
   output logic      rise
);
   typedef struct packed {
      logic [2:0] pipe;
      logic       level;
   } lcb_sync_st_t;
   lcb_sync_st_t st_reg;
   lcb_sync_st_t st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.pipe = {st_reg.pipe[1:0], async_in};
      if (st_reg.pipe[2] == st_reg.pipe[1]) begin
         st_next.level = st_reg.pipe[1];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign rise = ce && (st_reg.pipe[2] == st_reg.pipe[1]) && st_reg.pipe[1] && !st_reg.level;
endmodule

// ==== rtl/lcb_divider.sv ====
`timescale 1ns/1ps
module lcb_divider #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             tick_in,
   input  wire logic [WIDTH-1:0] limit,
   output logic                  tick_out
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
   } lcb_div_st_t;
   lcb_div_st_t st_reg;
   lcb_div_st_t st_next;

   always_comb begin
      st_next = st_reg;
      if (tick_in) begin
         if (st_reg.count >= limit) begin
            st_next.count = '0;
         end else begin
            st_next.count = st_reg.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign tick_out = ce && tick_in && (st_reg.count >= limit);
endmodule

// ==== testbench/lcb_glass_model.sv ====
`timescale 1ns/1ps
module lcb_glass_model #(
   parameter int XTAL_HALF_NS  = 20,
   parameter int LFOSC_HALF_NS = 30
) (
   input  wire logic        osc_en,
   input  wire logic [31:0] pixel_bit,
   output logic             xtal_clk,
   output logic             lfosc_clk,
   output logic      [5:0]  dark_count
);
   initial begin
      xtal_clk = 1'b0;
      lfosc_clk = 1'b0;
   end
   always #(XTAL_HALF_NS) xtal_clk = osc_en ? ~xtal_clk : 1'b0;
   always #(LFOSC_HALF_NS) lfosc_clk = ~lfosc_clk;
   assign dark_count = 6'($countones(pixel_bit));
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`include "lcb_defs.svh"
module testbench;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        sleep = 1'b0;
   logic        osc_en = 1'b0;
   logic        ce = 1'b1;
   logic        xtal_clk, lfosc_clk, ladder_connected, ladder_mid_short;
   logic        display_active_flag, frame_tick, seen_a, seen_b;
   logic [7:0]  rdata, v;
   logic [31:0] pixel_bit, exp_pix;
   logic [1:0]  ladder_power, bias_mode, frame_phase, ph;
   logic [5:0]  dark_count;
   int          n_errors = 0, checks = 0, cycles = 0, seed = 89511, n, p;
   int          per[4] = '{0, 16, 24, 0};

   always #5 clock = ~clock;

   lcb_core uut (.clock, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .sleep,
      .xtal_clk, .lfosc_clk, .pixel_bit, .ladder_power, .ladder_connected,
      .ladder_mid_short, .bias_mode, .display_active_flag, .frame_tick, .frame_phase);
   lcb_glass_model glass (.osc_en, .pixel_bit, .xtal_clk, .lfosc_clk, .dark_count);

   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
      #1;
   endtask

   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clock);
      #1;
   endtask

   task automatic gap(output int c);
      c = 0;
      do begin
         @(posedge clock);
         #1 c++;
      end while (frame_tick !== 1'b1 && c < 9000);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles > 80000) begin
         n_errors++;
         conclude();
      end
   end

   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1 check(bias_mode, 2);
      // Reset values and an unmapped place
      foreach (per[i]) begin
         rreg(8'(i == 3 ? 8'h20 : i), v);
         check(v, 0);
      end
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         exp_pix[8*i +: 8] = v;
         wreg(8'(`LCB_OFF_PIXEL0 + i), v);
      end
      check(pixel_bit, exp_pix);
      check(dark_count, $countones(exp_pix));
      for (int i = 0; i < 4; i++) begin
         rreg(8'(`LCB_OFF_PIXEL0 + i), v);
         check(v, exp_pix[8*i +: 8]);
      end
      wreg(`LCB_OFF_LADDER, 8'hff);
      rreg(`LCB_OFF_LADDER, v);
      check(v, 8'hf7);
      check(ladder_connected, 0);
      for (int i = 0; i < 4; i++) begin
         wreg(`LCB_OFF_CTRL, 8'(8'h80 | (i << 2)));
         check(bias_mode, i == 0 ? 2 : (i == 1 ? 1 : 0));
         check(ladder_mid_short, i == 1);
      end
      check(display_active_flag, 1);
      for (int c = 0; c < 4; c++) begin
         wreg(`LCB_OFF_LADDER, 8'(c * 8'h50));
         check(ladder_power, c);
         check(ladder_connected, c != 0);
      end
      wreg(`LCB_OFF_CTRL, 8'h80);
      for (int k = 0; k < 3; k++) begin
         p = k == 2 ? ($random(seed) & 15) : k * 15;
         wreg(`LCB_OFF_PRESCALE, 8'(p));
         rreg(`LCB_OFF_PRESCALE, v);
         check(v, p);
         gap(n);
         ph = frame_phase;
         gap(n);
         check(n, 256 * (p + 1));
         check(frame_phase, 2'(ph + 2'd1));
      end
      wreg(`LCB_OFF_PRESCALE, 8'h00);
      sleep <= 1'b1;
      gap(n);
      gap(n);
      check(n, 9000);
      osc_en <= 1'b1;
      wreg(`LCB_OFF_PRESCALE, 8'h03);
      for (int i = 1; i < 4; i++) begin
         wreg(`LCB_OFF_CTRL, 8'(8'h80 | i));
         gap(n);
         gap(n);
         check(i == 3 ? n == 9000 : (n >= per[i] - 1 && n <= per[i] + 1), 1);
      end
      wreg(`LCB_OFF_CTRL, 8'h81);
      wreg(`LCB_OFF_PRESCALE, 8'h0a);
      wreg(`LCB_OFF_LADDER, 8'hd7);
      gap(n);
      @(posedge clock);
      #1 check(ladder_power, 3);
      repeat (30) @(posedge clock);
      check(ladder_power, 3);
      wreg(`LCB_OFF_LADDER, 8'hd0);
      gap(n);
      @(posedge clock);
      #1 check(ladder_power, 1);
      wreg(`LCB_OFF_LADDER, 8'hd1);
      seen_a = 1'b0;
      seen_b = 1'b0;
      repeat (600) begin
         @(posedge clock);
         #1 seen_a |= ladder_power === 2'd3;
         seen_b |= ladder_power === 2'd1;
      end
      check({seen_a, seen_b}, 2'b11);
      ph = frame_phase;
      ce <= 1'b0;
      repeat (100) @(posedge clock);
      #1 check(frame_phase, ph);
      check(pixel_bit, exp_pix);
      ce <= 1'b1;
      @(posedge clock);
      #1;
      wreg(`LCB_OFF_CTRL, 8'h01);
      check(display_active_flag, 0);
      check(ladder_power, 0);
      conclude();
   end
endmodule
